// *** hw/hpt_cfg.svh ***
// address map, field positions, reset values and codes of the port tune and link status bank
`ifndef HPT_CFG_SVH
`define HPT_CFG_SVH

// register word indices; the byte address on the bus is four times the index
`define HPT_P1_DRIVE_IDX 15'h64CA
`define HPT_P1_SQUELCH_IDX 15'h64CC
`define HPT_P1_LINK_IDX 15'h65C0
`define HPT_P2_DRIVE_IDX 15'h68CA
`define HPT_P2_SQUELCH_IDX 15'h68CC
`define HPT_P2_LINK_IDX 15'h69C0

// bus geometry
`define HPT_ADR_W 17
`define HPT_DAT_W 32
`define HPT_IDX_W 15
`define HPT_REG_W 8

// tune field, bits 2:0 of the drive and squelch registers
`define HPT_FIELD_W 3
`define HPT_FIELD_MSB 2
`define HPT_TUNE_RESET 3'h0

// drive codes with no defined effect, and the nominal code the phy is sent in their place
`define HPT_DRIVE_NOMINAL 3'h0
`define HPT_DRIVE_UNDEF_A 3'h3
`define HPT_DRIVE_UNDEF_B 3'h6

// link status layout
`define HPT_STATE_W 4
`define HPT_SUB_W 3
`define HPT_STATUS_RESET 8'h00
`define HPT_RSVD_ZERO 1'h0

`endif

// *** hw/hpt_pkg.sv ***
// types and shared functions of the port tune and link status bank
`include "hpt_cfg.svh"

package hpt_pkg;

	// link state encoding reported in status bits 7:4
	typedef enum logic [3:0] {
		LS_U0 = 4'h0,
		LS_U1 = 4'h1,
		LS_U2 = 4'h2,
		LS_U3 = 4'h3,
		LS_DISABLED = 4'h4,
		LS_RX_DETECT = 4'h5,
		LS_SS_INACTIVE = 4'h6,
		LS_POLLING = 4'h7,
		LS_RECOVERY = 4'h8,
		LS_HOT_RESET = 4'h9,
		LS_COMPLIANCE = 4'hA,
		LS_LOOPBACK = 4'hB
	} hpt_link_state_type;

	// register selected by a bus address
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_P1_DRIVE,
		SEL_P1_SQUELCH,
		SEL_P1_LINK,
		SEL_P2_DRIVE,
		SEL_P2_SQUELCH,
		SEL_P2_LINK
	} hpt_sel_type;

	// drive code as the phy sees it: undefined codes fall back to nominal
	function automatic logic [`HPT_FIELD_MSB:0] hpt_resolve_drive(input logic [`HPT_FIELD_MSB:0] code);
		logic [`HPT_FIELD_MSB:0] res;
		res = code;
		if (code == `HPT_DRIVE_UNDEF_A || code == `HPT_DRIVE_UNDEF_B) begin
			res = `HPT_DRIVE_NOMINAL;
		end
		return res;
	endfunction : hpt_resolve_drive

endpackage : hpt_pkg

// *** hw/hpt_port_tune.sv ***
// drive and squelch tune fields of one downstream port
`timescale 1ns/10ps
`include "hpt_cfg.svh"

module hpt_port_tune
	import hpt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic drive_we_i,
	input wire logic squelch_we_i,
	input wire logic [`HPT_FIELD_MSB:0] wr_field_i,
	output logic [`HPT_FIELD_MSB:0] drive_reg_o,
	output logic [`HPT_FIELD_MSB:0] squelch_reg_o,
	output logic [`HPT_FIELD_MSB:0] phy_drive_o,
	output logic [`HPT_FIELD_MSB:0] phy_squelch_o
);

	logic [`HPT_FIELD_MSB:0] drive_reg;
	logic [`HPT_FIELD_MSB:0] drive_next;
	logic [`HPT_FIELD_MSB:0] squelch_reg;
	logic [`HPT_FIELD_MSB:0] squelch_next;
	logic [`HPT_FIELD_MSB:0] phy_drive_reg;
	logic [`HPT_FIELD_MSB:0] phy_drive_next;

	// stored fields keep what software wrote; only the phy copy is resolved
	always_comb begin
		drive_next = drive_reg;
		squelch_next = squelch_reg;
		if (drive_we_i) begin
			drive_next = wr_field_i;
		end
		if (squelch_we_i) begin
			squelch_next = wr_field_i;
		end
		phy_drive_next = hpt_resolve_drive(drive_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_reg <= `HPT_TUNE_RESET;
			squelch_reg <= `HPT_TUNE_RESET;
			phy_drive_reg <= `HPT_DRIVE_NOMINAL;
		end else begin
			drive_reg <= drive_next;
			squelch_reg <= squelch_next;
			phy_drive_reg <= phy_drive_next;
		end
	end

	// every squelch code has a defined trip point, so the field drives the phy as is
	assign drive_reg_o = drive_reg;
	assign squelch_reg_o = squelch_reg;
	assign phy_drive_o = phy_drive_reg;
	assign phy_squelch_o = squelch_reg;

endmodule : hpt_port_tune

// *** hw/hpt_link_status.sv ***
// read-only link state and sub-state capture of one downstream port
`timescale 1ns/10ps
`include "hpt_cfg.svh"

module hpt_link_status
	import hpt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [`HPT_STATE_W-1:0] link_state_i,
	input wire logic [`HPT_SUB_W-1:0] link_sub_state_i,
	output logic [`HPT_REG_W-1:0] status_reg_o
);

	logic [`HPT_REG_W-1:0] status_reg;
	logic [`HPT_REG_W-1:0] status_next;

	// state in 7:4, reserved zero in 3, sub-state in 2:0; no bus path writes here
	always_comb begin
		status_next = {link_state_i, `HPT_RSVD_ZERO, link_sub_state_i};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= `HPT_STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	assign status_reg_o = status_reg;

endmodule : hpt_link_status

// *** hw/hpt_regs.sv ***
// wishbone register bank for the drive, squelch and link status of two downstream ports
// Contract
// - drive register holds a writable 3-bit current adjust code in bits 2:0
// - duplicate drive codes: 101 is +15%, 111 is +25%; 011 and 110 give nominal
// - squelch register holds a writable 3-bit trip point adjust code in bits 2:0
// - squelch 110 raises 25mV, 111 raises 12.5mV; 011 lowers 37.5mV on both ports
// - status register shows link state in 7:4, sub-state in 2:0, bit 3 reserved
// - link state codes 00h to 0Bh name U0 through Loopback
// - each port has its own three registers, each touching only that port
`timescale 1ns/10ps
`include "hpt_cfg.svh"

module hpt_regs
	import hpt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`HPT_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [`HPT_DAT_W-1:0] wb_dat_i,
	output logic [`HPT_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [`HPT_STATE_W-1:0] p1_link_state_i,
	input wire logic [`HPT_SUB_W-1:0] p1_link_sub_state_i,
	input wire logic [`HPT_STATE_W-1:0] p2_link_state_i,
	input wire logic [`HPT_SUB_W-1:0] p2_link_sub_state_i,
	output logic [`HPT_FIELD_MSB:0] p1_hs_drive_adjust_o,
	output logic [`HPT_FIELD_MSB:0] p1_squelch_threshold_adjust_o,
	output logic [`HPT_FIELD_MSB:0] p2_hs_drive_adjust_o,
	output logic [`HPT_FIELD_MSB:0] p2_squelch_threshold_adjust_o
);

	// word index of a bus address; byte lanes below bit 2 are not decoded
	function automatic hpt_sel_type hpt_decode(input logic [`HPT_ADR_W-1:0] adr);
		logic [`HPT_IDX_W-1:0] idx;
		hpt_sel_type sel;
		idx = adr[`HPT_ADR_W-1:2];
		sel = SEL_NONE;
		if (idx == `HPT_P1_DRIVE_IDX) begin
			sel = SEL_P1_DRIVE;
		end else if (idx == `HPT_P1_SQUELCH_IDX) begin
			sel = SEL_P1_SQUELCH;
		end else if (idx == `HPT_P1_LINK_IDX) begin
			sel = SEL_P1_LINK;
		end else if (idx == `HPT_P2_DRIVE_IDX) begin
			sel = SEL_P2_DRIVE;
		end else if (idx == `HPT_P2_SQUELCH_IDX) begin
			sel = SEL_P2_SQUELCH;
		end else if (idx == `HPT_P2_LINK_IDX) begin
			sel = SEL_P2_LINK;
		end
		return sel;
	endfunction : hpt_decode

	// zero-extends an 8-bit register onto the 32-bit data bus
	function automatic logic [`HPT_DAT_W-1:0] hpt_widen(input logic [`HPT_REG_W-1:0] val);
		return {{(`HPT_DAT_W - `HPT_REG_W){1'b0}}, val};
	endfunction : hpt_widen

	logic ack_reg;
	logic ack_next;
	logic [`HPT_DAT_W-1:0] dat_reg;
	logic [`HPT_DAT_W-1:0] dat_next;
	logic req_new;
	logic wr_lane0;
	hpt_sel_type req_sel;
	logic p1_drive_we;
	logic p1_squelch_we;
	logic p2_drive_we;
	logic p2_squelch_we;
	logic [`HPT_FIELD_MSB:0] p1_drive_val;
	logic [`HPT_FIELD_MSB:0] p1_squelch_val;
	logic [`HPT_FIELD_MSB:0] p2_drive_val;
	logic [`HPT_FIELD_MSB:0] p2_squelch_val;
	logic [`HPT_REG_W-1:0] p1_status_val;
	logic [`HPT_REG_W-1:0] p2_status_val;

	// a request is new until the ack it earned is on the bus; this keeps one write per transfer
	assign req_new = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign req_sel = hpt_decode(wb_adr_i);
	// only lane 0 carries register bits; a write without it changes nothing
	assign wr_lane0 = req_new & wb_we_i & wb_sel_i[0];

	// strobes toward each port are decoded apart so no write crosses ports
	always_comb begin
		p1_drive_we = 1'b0;
		p1_squelch_we = 1'b0;
		p2_drive_we = 1'b0;
		p2_squelch_we = 1'b0;
		if (wr_lane0) begin
			case (req_sel)
				SEL_P1_DRIVE: begin
					p1_drive_we = 1'b1;
				end
				SEL_P1_SQUELCH: begin
					p1_squelch_we = 1'b1;
				end
				SEL_P2_DRIVE: begin
					p2_drive_we = 1'b1;
				end
				SEL_P2_SQUELCH: begin
					p2_squelch_we = 1'b1;
				end
				default: begin
					// link status and unmapped words take no write
					p1_drive_we = 1'b0;
				end
			endcase
		end
	end

	// port one tune fields
	hpt_port_tune u_p1_tune (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.drive_we_i(p1_drive_we),
		.squelch_we_i(p1_squelch_we),
		.wr_field_i(wb_dat_i[`HPT_FIELD_MSB:0]),
		.drive_reg_o(p1_drive_val),
		.squelch_reg_o(p1_squelch_val),
		.phy_drive_o(p1_hs_drive_adjust_o),
		.phy_squelch_o(p1_squelch_threshold_adjust_o)
	);

	// port two tune fields
	hpt_port_tune u_p2_tune (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.drive_we_i(p2_drive_we),
		.squelch_we_i(p2_squelch_we),
		.wr_field_i(wb_dat_i[`HPT_FIELD_MSB:0]),
		.drive_reg_o(p2_drive_val),
		.squelch_reg_o(p2_squelch_val),
		.phy_drive_o(p2_hs_drive_adjust_o),
		.phy_squelch_o(p2_squelch_threshold_adjust_o)
	);

	// port one link status
	hpt_link_status u_p1_link (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.link_state_i(p1_link_state_i),
		.link_sub_state_i(p1_link_sub_state_i),
		.status_reg_o(p1_status_val)
	);

	// port two link status
	hpt_link_status u_p2_link (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.link_state_i(p2_link_state_i),
		.link_sub_state_i(p2_link_sub_state_i),
		.status_reg_o(p2_status_val)
	);

	// ack one cycle after a request, dropped the cycle after; unmapped words ack with zero
	always_comb begin
		ack_next = req_new;
		dat_next = '0;
		if (req_new && !wb_we_i) begin
			case (req_sel)
				SEL_P1_DRIVE: begin
					dat_next = hpt_widen({5'h00, p1_drive_val});
				end
				SEL_P1_SQUELCH: begin
					dat_next = hpt_widen({5'h00, p1_squelch_val});
				end
				SEL_P1_LINK: begin
					dat_next = hpt_widen(p1_status_val);
				end
				SEL_P2_DRIVE: begin
					dat_next = hpt_widen({5'h00, p2_drive_val});
				end
				SEL_P2_SQUELCH: begin
					dat_next = hpt_widen({5'h00, p2_squelch_val});
				end
				SEL_P2_LINK: begin
					dat_next = hpt_widen(p2_status_val);
				end
				default: begin
					dat_next = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	// data is zero outside an ack, so a stale read never lingers on the bus
	assign wb_dat_o = dat_reg;

	// a write to the port one drive register lands in that field one edge later
	a_drive_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		p1_drive_we |=> p1_drive_val == $past(wb_dat_i[`HPT_FIELD_MSB:0]))
	else $error("port one drive field did not take the written code");

	// the phy sees the resolved drive code; undefined codes show as nominal
	a_drive_resolve_map: assert property (@(posedge clk_i) disable iff (rst_i)
		(p1_drive_val == `HPT_DRIVE_UNDEF_A || p1_drive_val == `HPT_DRIVE_UNDEF_B) |->
		p1_hs_drive_adjust_o == `HPT_DRIVE_NOMINAL && p2_hs_drive_adjust_o == hpt_resolve_drive(p2_drive_val))
	else $error("drive code reached the phy unresolved");

	// a port two squelch write lands in its field one edge later, with the ack on the bus
	a_squelch_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		p2_squelch_we |=> p2_squelch_val == $past(wb_dat_i[`HPT_FIELD_MSB:0]) && wb_ack_o)
	else $error("port two squelch field did not take the written code");

	// every squelch code, the raised ones included, passes to the phy unchanged
	a_squelch_phy_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		p1_squelch_threshold_adjust_o == p1_squelch_val && p2_squelch_threshold_adjust_o == p2_squelch_val)
	else $error("squelch phy code differs from the stored field");

	// a port one status read returns its inputs as they stood two edges before the ack
	a_status_read_layout: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !wb_we_i && req_sel == SEL_P1_LINK |->
		wb_dat_o[`HPT_REG_W-1:0] == {$past(p1_link_state_i, 2), 1'b0, $past(p1_link_sub_state_i, 2)})
	else $error("port one status read does not match the link inputs");

	// port two's state field carries the loopback code one edge after its own input does
	a_state_code_field: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && $past(p2_link_state_i) == LS_LOOPBACK |-> p2_status_val[7:4] == 4'hB)
	else $error("port two state field lost the loopback code");

	// a write to port one leaves port two untouched
	a_port_isolation: assert property (@(posedge clk_i) disable iff (rst_i)
		(p1_drive_we || p1_squelch_we) |=> $stable(p2_drive_val) && $stable(p2_squelch_val))
	else $error("a port one write disturbed port two");

	// a write aimed at a status word changes no tune field on either port
	a_readonly_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && wb_we_i && (req_sel == SEL_P1_LINK || req_sel == SEL_P2_LINK) |=>
		$stable(p1_drive_val) && $stable(p2_drive_val) && $stable(p1_squelch_val) && $stable(p2_squelch_val))
	else $error("a write to a read-only status word changed a field");

	// reserved bits of a status read are zero
	a_reserved_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !wb_we_i && (req_sel == SEL_P1_LINK || req_sel == SEL_P2_LINK) |->
		wb_dat_o[3] == 1'b0 && wb_dat_o[`HPT_DAT_W-1:`HPT_REG_W] == '0)
	else $error("reserved status bits read as nonzero");

	// each request gets exactly one ack pulse, one cycle after it is seen
	a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new |=> wb_ack_o ##1 !wb_ack_o)
	else $error("ack did not pulse once for a request");

	// read data stays zero outside an ack, so nothing stale can be mistaken for an answer
	a_dat_idle_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> wb_dat_o == '0)
	else $error("read data is nonzero outside an ack");

	// a write is answered with zero data
	a_write_ack_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && wb_we_i |-> wb_dat_o == '0)
	else $error("write ack carried nonzero data");

	// an unmapped read is still answered, with zero
	a_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && !wb_we_i && req_sel == SEL_NONE |=> wb_ack_o && wb_dat_o == '0)
	else $error("unmapped read was not answered with zero");

	// tune registers hold three bits only; the bits above read zero
	a_tune_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && !wb_we_i && (req_sel == SEL_P1_DRIVE || req_sel == SEL_P1_SQUELCH || req_sel == SEL_P2_DRIVE ||
		req_sel == SEL_P2_SQUELCH) |=> wb_dat_o[`HPT_REG_W-1:`HPT_FIELD_W] == '0)
	else $error("tune register read shows bits above the field");

	// a port one drive read returns the stored code, not the resolved phy code
	a_drive_readback: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && !wb_we_i && req_sel == SEL_P1_DRIVE |=> wb_dat_o[`HPT_FIELD_MSB:0] == $past(p1_drive_val))
	else $error("port one drive read-back differs from the field");

	// a port two squelch read returns the stored code
	a_squelch_readback: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && !wb_we_i && req_sel == SEL_P2_SQUELCH |=> wb_dat_o[`HPT_FIELD_MSB:0] == $past(p2_squelch_val))
	else $error("port two squelch read-back differs from the field");

	// a write without the low byte lane touches no field
	a_lane_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		req_new && wb_we_i && !wb_sel_i[0] |=>
		$stable(p1_drive_val) && $stable(p1_squelch_val) && $stable(p2_drive_val) && $stable(p2_squelch_val))
	else $error("a write without lane 0 changed a field");

	// a port two drive write lands one edge later
	a_p2_drive_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		p2_drive_we |=> p2_drive_val == $past(wb_dat_i[`HPT_FIELD_MSB:0]))
	else $error("port two drive field did not take the written code");

	// a port one squelch write lands one edge later
	a_p1_squelch_lands: assert property (@(posedge clk_i) disable iff (rst_i)
		p1_squelch_we |=> p1_squelch_val == $past(wb_dat_i[`HPT_FIELD_MSB:0]))
	else $error("port one squelch field did not take the written code");

	// a write to port two leaves port one untouched
	a_port2_isolation: assert property (@(posedge clk_i) disable iff (rst_i)
		(p2_drive_we || p2_squelch_we) |=> $stable(p1_drive_val) && $stable(p1_squelch_val))
	else $error("a port two write disturbed port one");

	// a port two status read returns its link inputs two edges before the ack
	a_p2_status_layout: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && !wb_we_i && req_sel == SEL_P2_LINK |->
		wb_dat_o[`HPT_REG_W-1:0] == {$past(p2_link_state_i, 2), 1'b0, $past(p2_link_sub_state_i, 2)})
	else $error("port two status read does not match the link inputs");

	// defined port one drive codes reach the phy unchanged
	a_drive_defined_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		!(p1_drive_val == `HPT_DRIVE_UNDEF_A || p1_drive_val == `HPT_DRIVE_UNDEF_B) |-> p1_hs_drive_adjust_o == p1_drive_val)
	else $error("a defined drive code was altered on its way to the phy");

	// port one status follows its inputs one edge late; the edge after reset is skipped
	a_state_tracks_port: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |->
		p1_status_val == {$past(p1_link_state_i), 1'b0, $past(p1_link_sub_state_i)})
	else $error("port one status does not follow its link inputs");

	// port two status follows its own inputs, never port one's
	a_p2_state_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |->
		p2_status_val == {$past(p2_link_state_i), 1'b0, $past(p2_link_sub_state_i)})
	else $error("port two status does not follow its link inputs");

	// an ack is only ever earned by a request seen the edge before
	a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(req_new))
	else $error("ack appeared without a request");

	// reset leaves every field and phy code at nominal and the bus quiet
	a_reset_clears_tune: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> p1_hs_drive_adjust_o == `HPT_DRIVE_NOMINAL && p2_hs_drive_adjust_o == `HPT_DRIVE_NOMINAL &&
		p1_squelch_val == `HPT_TUNE_RESET && p2_squelch_val == `HPT_TUNE_RESET && !wb_ack_o)
	else $error("reset did not clear the tune fields");

endmodule : hpt_regs

// *** tb/test_hpt_regs.sv ***
// self-checking bench for the port tune and link status register bank
`timescale 1ns/10ps
`include "hpt_cfg.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
	$display("Error at %0t: got %0h expected %0h", $time, got, exp); end end

module test_hpt_regs;
	import hpt_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [16:0] wb_adr_i = 17'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [3:0] ls_i[2] = '{4'h0, 4'h0};
	logic [2:0] sub_i[2] = '{3'h0, 3'h0};
	logic [2:0] drv_o[2];
	logic [2:0] sq_o[2];
	logic [2:0] drv_m[2] = '{3'h0, 3'h0};
	logic [2:0] sq_m[2] = '{3'h0, 3'h0};
	logic [16:0] drv_adr[2] = '{{`HPT_P1_DRIVE_IDX, 2'b00}, {`HPT_P2_DRIVE_IDX, 2'b00}};
	logic [16:0] sq_adr[2] = '{{`HPT_P1_SQUELCH_IDX, 2'b00}, {`HPT_P2_SQUELCH_IDX, 2'b00}};
	logic [16:0] st_adr[2] = '{{`HPT_P1_LINK_IDX, 2'b00}, {`HPT_P2_LINK_IDX, 2'b00}};
	logic [31:0] lfsr_reg = 32'hD1EAFD6C;
	logic [31:0] rnd_val;
	logic [31:0] exp_q[$];
	logic [31:0] mon_exp;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;

	hpt_regs u_hpt_regs (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.p1_link_state_i(ls_i[0]), .p1_link_sub_state_i(sub_i[0]),
		.p2_link_state_i(ls_i[1]), .p2_link_sub_state_i(sub_i[1]),
		.p1_hs_drive_adjust_o(drv_o[0]), .p1_squelch_threshold_adjust_o(sq_o[0]),
		.p2_hs_drive_adjust_o(drv_o[1]), .p2_squelch_threshold_adjust_o(sq_o[1])
	);

	// 250 MHz
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	function automatic logic [31:0] rnd();
		lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
		return lfsr_reg;
	endfunction : rnd

	// undefined drive codes reach the phy as nominal
	function automatic logic [2:0] phy_drive(input logic [2:0] c);
		return (c == 3'h3 || c == 3'h6) ? 3'h0 : c;
	endfunction : phy_drive

	task wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	// one classic cycle; the expected read data is noted before the request goes out
	task wb_xfer(input logic we, input logic [16:0] adr, input logic [3:0] sel, input logic [31:0] dat,
		input logic [31:0] exp);
		exp_q.push_back(exp);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		// no fixed latency is assumed; only the cycle guard ends a missing ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb_xfer

	// read back both ports and look at the phy side against the model
	task check_all();
		for (int p = 0; p < 2; p++) begin
			wb_xfer(1'b0, drv_adr[p], 4'hF, 32'h0, {29'h0, drv_m[p]});
			wb_xfer(1'b0, sq_adr[p], 4'hF, 32'h0, {29'h0, sq_m[p]});
			`CHK(drv_o[p], phy_drive(drv_m[p]))
			`CHK(sq_o[p], sq_m[p])
		end
	endtask : check_all

	// watcher: every ack retires the oldest note
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("Error at %0t: unexpected ack", $time);
			end else begin
				mon_exp = exp_q.pop_front();
				`CHK(wb_dat_o, mon_exp)
			end
		end
	end

	// hang guard, well above the fewer than a thousand cycles the sequence needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("Error at %0t: timeout", $time);
			wrap_up();
		end
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		check_all();
		// every drive code, then every squelch code, on each port; the other port must hold
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 8; c++) begin
				drv_m[p] = c[2:0];
				rnd_val = rnd();
				wb_xfer(1'b1, drv_adr[p], 4'h1, {rnd_val[31:3], c[2:0]}, 32'h0);
				check_all();
			end
			for (int c = 0; c < 8; c++) begin
				sq_m[p] = c[2:0];
				rnd_val = rnd();
				wb_xfer(1'b1, sq_adr[p], 4'h1, {rnd_val[31:3], c[2:0]}, 32'h0);
				check_all();
			end
		end
		// every link state on one port, a different one on the other; writes there change nothing
		for (int s = 0; s < 12; s++) begin
			ls_i[0] <= s[3:0];
			ls_i[1] <= 4'hB - s[3:0];
			rnd_val = rnd();
			sub_i[0] <= rnd_val[2:0];
			sub_i[1] <= rnd_val[6:4];
			repeat (2) @(posedge clk_i);
			for (int p = 0; p < 2; p++) begin
				wb_xfer(1'b1, st_adr[p], 4'hF, rnd(), 32'h0);
				wb_xfer(1'b0, st_adr[p], 4'hF, 32'h0, {24'h0, ls_i[p], 1'b0, sub_i[p]});
			end
		end
		check_all();
		// disabled low lane and an unmapped place are both ignored
		rnd_val = rnd();
		wb_xfer(1'b1, drv_adr[0], 4'hE, {rnd_val[31:3], ~drv_m[0]}, 32'h0);
		wb_xfer(1'b1, 17'h00100, 4'hF, rnd(), 32'h0);
		wb_xfer(1'b0, 17'h00100, 4'hF, 32'h0, 32'h0);
		check_all();
		// reset in mid-run clears the tune fields
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		drv_m = '{3'h0, 3'h0};
		sq_m = '{3'h0, 3'h0};
		check_all();
		wrap_up();
	end
endmodule : test_hpt_regs
